// [logic/amb_cfg_pkg.sv]
// Shared constants for the ambient tracking configuration register bank.
// Assumes a 16-bit register port driven by the serial interface decoder.
package amb_cfg_pkg;

  localparam logic [9:0]  ADDR_AMB0     = 10'h002;
  localparam logic [9:0]  ADDR_AMB1     = 10'h003;
  localparam logic [9:0]  ADDR_AMB2     = 10'h004;
  localparam logic [9:0]  ADDR_LOW_EN   = 10'h005;

  localparam logic [15:0] RST_AMB0      = 16'h0ff0;
  localparam logic [15:0] RST_AMB1      = 16'h0140;
  localparam logic [15:0] RST_AMB2      = 16'hffff;
  localparam logic [15:0] RST_LOW_EN    = 16'h0000;

  localparam int SKIP_LSB       = 0;
  localparam int FP_HOLD_LSB    = 4;
  localparam int LP_HOLD_LSB    = 8;
  localparam int TIMEOUT_LSB    = 12;
  localparam int FORCE_CAL_BIT  = 14;
  localparam int RESTART_BIT    = 15;
  localparam int FP_RECAL_LSB   = 0;
  localparam int LP_RECAL_LSB   = 10;
  localparam int GPIO_SETUP_LSB = 12;
  localparam int GPIO_MODE_LSB  = 14;
  localparam int GPIO_INT_BIT   = 12;

  localparam int FP_HOLD_MULT   = 16;
  localparam int LP_HOLD_MULT   = 4;

  typedef enum logic [1:0] {
    PIN_OFF, PIN_INPUT, PIN_OUT_LOW_ACTIVE, PIN_OUT_HIGH_ACTIVE
  } pin_setup_t;

  typedef enum logic [1:0] {
    TRIG_LOW_LEVEL, TRIG_RISE, TRIG_FALL, TRIG_HIGH_LEVEL
  } pin_trigger_t;

endpackage : amb_cfg_pkg

// [logic/seq_counter.sv]
// Counts conversion sequences and flags when a programmed number is reached.
// Assumes a one-cycle pulse per finished sequence; restart clears the count.
module seq_counter #(
  parameter int W = 12
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              reached,
  output logic [W-1:0]      count
);

  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (tick && !reached) begin
      next_count = count + W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign reached = (count >= limit);

endmodule : seq_counter

// [logic/touch_ambient_comp_config_regs.sv]
// Ambient compensation configuration registers with their timing helpers.
// Assumes a decoded 16-bit register port and a conversion sequencer that
// reports sequence ends, stage low events and a power mode flag.
module touch_ambient_comp_config_regs
  import amb_cfg_pkg::*;
#(
  parameter int STAGES = 12
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              soft_reset,
  input  wire logic [9:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  input  wire logic              low_power_mode,
  input  wire logic              seq_done,
  input  wire logic              lp_seq_done,
  input  wire logic [STAGES-1:0] stage_low_event,
  input  wire logic              gpio_enable_int,
  input  wire logic              gpio_in,
  output logic                   gpio_out,
  output logic                   gpio_oe_n,
  output logic                   fifo_admit,
  output logic                   cal_hold,
  output logic                   power_drop,
  output logic                   force_recal,
  output logic                   sequence_restart,
  output logic [9:0]             full_power_recal_time,
  output logic [5:0]             low_power_recal_time,
  output logic                   irq
);

  // ==========================================================================
  // Register storage
  // The restart bit is never stored: it lives only as a one-cycle pulse,
  // so a read of the first register always shows it as zero.
  // A soft reset restores the same defaults as the pin reset, but it is
  // sampled on the clock, so a write in the same cycle is lost.
  logic [15:0] amb0, amb1, amb2, low_en;
  logic [15:0] next_amb0, next_amb1, next_amb2, next_low_en;
  logic        next_restart;
  logic        gpio_sync, gpio_prev;

  always_comb begin
    next_amb0    = amb0;
    next_amb1    = amb1;
    next_amb2    = amb2;
    next_low_en  = low_en;
    next_restart = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_AMB0: begin
          next_amb0 = reg_wdata;
          next_amb0[RESTART_BIT] = 1'b0;
          next_restart = reg_wdata[RESTART_BIT];
        end
        ADDR_AMB1:   next_amb1   = reg_wdata;
        ADDR_AMB2:   next_amb2   = reg_wdata;
        ADDR_LOW_EN: next_low_en = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      amb0             <= RST_AMB0;
      amb1             <= RST_AMB1;
      amb2             <= RST_AMB2;
      low_en           <= RST_LOW_EN;
      sequence_restart <= 1'b0;
    end else if (soft_reset) begin
      amb0             <= RST_AMB0;
      amb1             <= RST_AMB1;
      amb2             <= RST_AMB2;
      low_en           <= RST_LOW_EN;
      sequence_restart <= 1'b0;
    end else begin
      amb0             <= next_amb0;
      amb1             <= next_amb1;
      amb2             <= next_amb2;
      low_en           <= next_low_en;
      sequence_restart <= next_restart;
    end
  end

  // ==========================================================================
  // Read port
  // Read data is registered and held until the next read strobe, so the
  // host may sample it any time after the cycle that follows its strobe.
  // Unmapped reads return zero rather than a stale word.
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_AMB0:   next_rdata = amb0;
        ADDR_AMB1:   next_rdata = amb1;
        ADDR_AMB2:   next_rdata = amb2;
        ADDR_LOW_EN: next_rdata = low_en;
        default:     next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Field views
  // These are plain slices of the stored words; naming them keeps the
  // timing logic below readable and ties each field to its bit position.
  logic [3:0] fast_filter_skip_count;
  logic [3:0] full_power_cal_hold_count;
  logic [3:0] low_power_cal_hold_count;
  logic [1:0] power_drop_timeout;
  pin_setup_t   pin_setup;
  pin_trigger_t pin_trigger;

  assign fast_filter_skip_count    = amb0[SKIP_LSB +: 4];
  assign full_power_cal_hold_count = amb0[FP_HOLD_LSB +: 4];
  assign low_power_cal_hold_count  = amb0[LP_HOLD_LSB +: 4];
  assign power_drop_timeout        = amb0[TIMEOUT_LSB +: 2];
  assign force_recal               = amb0[FORCE_CAL_BIT];
  assign full_power_recal_time     = amb2[FP_RECAL_LSB +: 10];
  assign low_power_recal_time      = amb2[LP_RECAL_LSB +: 6];
  assign pin_setup   = pin_setup_t'(low_en[GPIO_SETUP_LSB +: 2]);
  assign pin_trigger = pin_trigger_t'(low_en[GPIO_MODE_LSB +: 2]);

  // ==========================================================================
  // Fast filter admission
  // A sequence is admitted when the skip counter has already passed N
  // sequences; the admitted sequence then clears it.
  // The count does not restart when the code changes, so a new code takes
  // effect from wherever the previous count stood; a restart aligns it.
  logic       skip_reached;
  logic [3:0] skip_cnt;

  seq_counter #(.W(4)) u_skip (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (sequence_restart || (seq_done && skip_reached)),
    .tick    (seq_done),
    .limit   (fast_filter_skip_count),
    .reached (skip_reached),
    .count   (skip_cnt)
  );

  assign fifo_admit = seq_done && skip_reached;

  // ==========================================================================
  // Calibration hold and power drop timing, counted in sequences
  // The hold counter restarts on mode change so each mode times afresh.
  // Ten bits cover the largest span, fifteen times sixteen sequences, and
  // the largest timeout, twice that span.
  logic       mode_prev;
  logic       hold_reached;
  logic       drop_reached;
  logic [9:0] hold_limit;
  logic [9:0] drop_limit;
  logic [9:0] hold_cnt;
  logic [9:0] drop_cnt;
  logic [9:0] fp_span;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_prev <= 1'b0;
    end else begin
      mode_prev <= low_power_mode;
    end
  end

  assign fp_span = 10'(full_power_cal_hold_count) * 10'(FP_HOLD_MULT);

  always_comb begin
    if (low_power_mode) begin
      hold_limit = 10'(low_power_cal_hold_count) * 10'(LP_HOLD_MULT);
    end else begin
      hold_limit = fp_span;
    end
  end

  // 1.25, 1.50, 1.75, 2.00 times the full power hold span: base plus quarters.
  assign drop_limit = fp_span + 10'((fp_span * (power_drop_timeout + 2'd1))
                                    >> 2);

  seq_counter #(.W(10)) u_hold (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (sequence_restart || force_recal ||
              (low_power_mode != mode_prev)),
    .tick    (low_power_mode ? lp_seq_done : seq_done),
    .limit   (hold_limit),
    .reached (hold_reached),
    .count   (hold_cnt)
  );

  // The drop timer only runs in full power mode; entering low power mode
  // clears it, so returning to full power times the full span again.
  seq_counter #(.W(10)) u_drop (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (sequence_restart || low_power_mode),
    .tick    (seq_done),
    .limit   (drop_limit),
    .reached (drop_reached),
    .count   (drop_cnt)
  );

  assign cal_hold   = !hold_reached && !force_recal;
  assign power_drop = drop_reached && !low_power_mode;

  // ==========================================================================
  // Pin control and trigger detection
  // Two flops give the edge detector its history. Both reset low, so a pin
  // that idles high shows one false rising edge after reset; the pin setup
  // field resets to off, which keeps that edge harmless.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_sync <= 1'b0;
      gpio_prev <= 1'b0;
    end else begin
      gpio_sync <= gpio_in;
      gpio_prev <= gpio_sync;
    end
  end

  logic gpio_trig;
  logic out_active;

  // The output pin shows the same enabled stage events that feed the
  // interrupt, in the polarity chosen by the setup field.
  assign out_active = |(stage_low_event & low_en[STAGES-1:0]);

  always_comb begin
    gpio_oe_n = 1'b1;
    gpio_out  = 1'b0;
    unique case (pin_setup)
      PIN_OFF, PIN_INPUT: ;
      PIN_OUT_LOW_ACTIVE: begin
        gpio_oe_n = 1'b0;
        gpio_out  = !out_active;
      end
      PIN_OUT_HIGH_ACTIVE: begin
        gpio_oe_n = 1'b0;
        gpio_out  = out_active;
      end
    endcase
  end

  always_comb begin
    unique case (pin_trigger)
      TRIG_LOW_LEVEL:  gpio_trig = !gpio_sync;
      TRIG_RISE:       gpio_trig = gpio_sync && !gpio_prev;
      TRIG_FALL:       gpio_trig = !gpio_sync && gpio_prev;
      TRIG_HIGH_LEVEL: gpio_trig = gpio_sync;
    endcase
  end

  // ==========================================================================
  // Interrupt
  // The interrupt is not sticky: it follows its sources one cycle late.
  // A host that needs to see short events must read them elsewhere.
  // The pin trigger only counts while the pin is set up as an input.
  logic next_irq;

  always_comb begin
    next_irq = |(stage_low_event & low_en[STAGES-1:0]) ||
               (gpio_enable_int && pin_setup == PIN_INPUT &&
                gpio_trig);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

endmodule : touch_ambient_comp_config_regs

// [tb/amb_cfg_props.sv]
// Checker for the ambient tracking register bank, bound to its top.
// Assumes one clock domain, clk_sys, with the low-active resetn.
module amb_cfg_props #(
  parameter int STAGES = 12
) (
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic              soft_reset,
  input wire logic [9:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              seq_done,
  input wire logic [STAGES-1:0] stage_low_event,
  input wire logic              gpio_enable_int,
  input wire logic              gpio_oe_n,
  input wire logic              fifo_admit,
  input wire logic              force_recal,
  input wire logic              sequence_restart,
  input wire logic [9:0]        full_power_recal_time,
  input wire logic [5:0]        low_power_recal_time,
  input wire logic              irq
);
  // ==========
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // A soft reset beats a write in the same cycle, so it is left out.
  wire logic wr0 = reg_wr && !soft_reset && reg_addr == 10'h002;
  wire logic wr2 = reg_wr && !soft_reset && reg_addr == 10'h004;
  wire logic wr3 = reg_wr && !soft_reset && reg_addr == 10'h005;
  wire logic unm = reg_addr < 10'h002 || reg_addr > 10'h005;

  property p_restart; wr0 && reg_wdata[15] |=> sequence_restart; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_self;
    sequence_restart |-> $past(wr0) && $past(reg_wdata[15]);
  endproperty
  a_self: assert property (p_self) else $error("restart stuck");
  property p_force; wr0 |=> force_recal == $past(reg_wdata[14]); endproperty
  a_force: assert property (p_force) else $error("force bit");
  property p_recal;
    wr2 |=> {low_power_recal_time, full_power_recal_time} == $past(reg_wdata);
  endproperty
  a_recal: assert property (p_recal) else $error("recal time");
  property p_unm; reg_rd && unm |=> reg_rdata == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hold; !reg_rd && !soft_reset |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_quiet;
    stage_low_event == '0 && !gpio_enable_int && !soft_reset |=> !irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("idle irq");
  property p_admit; fifo_admit |-> seq_done; endproperty
  a_admit: assert property (p_admit) else $error("stray admit");
  property p_pin; wr3 |=> gpio_oe_n == !$past(reg_wdata[13]); endproperty
  a_pin: assert property (p_pin) else $error("pin enable");
endmodule : amb_cfg_props

bind touch_ambient_comp_config_regs amb_cfg_props #(.STAGES(STAGES)) i_props (
  .clk_sys, .resetn, .soft_reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .seq_done, .stage_low_event, .gpio_enable_int, .gpio_oe_n,
  .fifo_admit, .force_recal, .sequence_restart, .full_power_recal_time,
  .low_power_recal_time, .irq
);

// [tb/host_model.sv]
// Host side model: issues single register writes and reads.
// Assumes the bench calls acc; strobes move on falling edges only.
module host_model (
  input  wire logic clk_sys,
  output logic [9:0]  reg_addr,
  output logic        reg_wr,
  output logic [15:0] reg_wdata,
  output logic        reg_rd
);
  // ==========
  // Access
  initial begin
    reg_addr = 10'h3ff;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end

  // Released address and data lines show the inverse so stale values are never trusted.
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : acc
endmodule : host_model

// [tb/tb.sv]
// Bench for the ambient tracking register bank with a host model.
// Assumes a one-cycle read latency and whole-word register accesses.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, resetn, soft_reset, seq_done, gpio_enable_int;
  logic        pin_drv, rd_d, low_power_mode, lp_seq_done;
  logic [11:0] stage_low_event;
  logic [15:0] exp_q[$];
  int          error_cnt, cmp_count;
  wire logic [9:0]  reg_addr;
  wire logic [15:0] reg_wdata, reg_rdata;
  wire logic        reg_wr, reg_rd, gpio_out, gpio_oe_n, fifo_admit;
  wire logic        force_recal, sequence_restart, irq, cal_hold, power_drop;
  // The pin reads back what the block drives while its enable is low.
  wire logic        gpio_in = gpio_oe_n ? pin_drv : gpio_out;

  host_model i_host (.clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  touch_ambient_comp_config_regs #(.STAGES(12)) i_dut (
    .clk_sys, .resetn, .soft_reset, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .low_power_mode, .seq_done,
    .lp_seq_done, .stage_low_event, .gpio_enable_int, .gpio_in,
    .gpio_out, .gpio_oe_n, .fifo_admit, .cal_hold, .power_drop,
    .force_recal, .sequence_restart, .full_power_recal_time(),
    .low_power_recal_time(), .irq
  );

  // ==========
  // Tasks
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    i_host.acc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_host.acc(1'b0, a, 16'h0000);
  endtask : rd
  task automatic ev(input logic [11:0] s, input logic g, p, e);
    @(negedge clk_sys);
    stage_low_event = s;
    gpio_enable_int = g;
    pin_drv = p;
    repeat (2) @(negedge clk_sys);
    chk({15'h0, irq}, {15'h0, e});
  endtask : ev
  // Sampled mid-cycle: the admit flag is combinational with seq_done.
  task automatic admits(input int n, input int e);
    int c;
    c = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      seq_done = 1'b1;
      #10;
      c += int'(fifo_admit === 1'b1);
      @(negedge clk_sys);
      seq_done = 1'b0;
    end
    chk(16'(c), 16'(e));
  endtask : admits
  task automatic lp_seqs(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      lp_seq_done = 1'b1;
      @(negedge clk_sys);
      lp_seq_done = 1'b0;
    end
  endtask : lp_seqs

  // ==========
  // Clock, checks and sequence
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1 && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
  initial begin
    logic [15:0] r;
    logic [9:0]  a;
    logic [15:0] dflt [5];
    dflt = '{16'h0ff0, 16'h0140, 16'hffff, 16'h0, 16'h0};
    {resetn, soft_reset, seq_done, gpio_enable_int, pin_drv} = 5'b0;
    {low_power_mode, lp_seq_done} = 2'b00;
    stage_low_event = 12'h000;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    for (int i = 0; i < 5; i++) rd(10'(i + 2), dflt[i]);
    r = 16'h770e;
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      a = 10'(2 + i % 4);
      wr(a, r);
      if (a == 10'h002) chk({15'h0, force_recal}, {15'h0, r[14]});
      rd(a, a == 10'h002 ? r & 16'h7fff : r);
    end
    wr(10'h002, 16'hcff0);
    chk({15'h0, force_recal}, 16'h0001);
    rd(10'h002, 16'h4ff0);
    wr(10'h002, 16'h0ff0);
    admits(4, 4);
    wr(10'h002, 16'h0ff1);
    admits(8, 4);
    wr(10'h002, 16'h0ffb);
    admits(12, 1);
    wr(10'h002, 16'h8110);
    admits(15, 15);
    chk({14'h0, cal_hold, power_drop}, 16'h0002);
    admits(1, 1);
    chk({14'h0, cal_hold, power_drop}, 16'h0000);
    admits(3, 3);
    chk({15'h0, power_drop}, 16'h0000);
    admits(1, 1);
    chk({15'h0, power_drop}, 16'h0001);
    @(negedge clk_sys);
    low_power_mode = 1'b1;
    lp_seqs(3);
    chk({14'h0, cal_hold, power_drop}, 16'h0002);
    lp_seqs(1);
    chk({15'h0, cal_hold}, 16'h0000);
    @(negedge clk_sys);
    low_power_mode = 1'b0;
    wr(10'h005, 16'hd010);
    ev(12'h008, 0, 0, 0);
    ev(12'h010, 0, 0, 1);
    ev(12'h000, 0, 1, 0);
    ev(12'h000, 1, 1, 1);
    wr(10'h005, 16'h1000);
    ev(12'h000, 1, 0, 1);
    wr(10'h005, 16'h9000);
    ev(12'h000, 1, 0, 0);
    ev(12'h000, 0, 1, 0);
    ev(12'h000, 1, 0, 1);
    ev(12'h000, 0, 1, 0);
    wr(10'h005, 16'h5000);
    ev(12'h000, 1, 1, 0);
    ev(12'h000, 1, 0, 0);
    ev(12'h000, 1, 1, 1);
    wr(10'h005, 16'h3010);
    ev(12'h010, 0, 0, 1);
    chk({14'h0, gpio_oe_n, gpio_out}, 16'h0001);
    wr(10'h005, 16'h2010);
    chk({14'h0, gpio_oe_n, gpio_out}, 16'h0000);
    @(negedge clk_sys);
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    rd(10'h004, 16'hffff);
    rd(10'h005, 16'h0000);
    repeat (3) @(negedge clk_sys);
    if (exp_q.size() != 0) error_cnt++;
    wrap_up();
  end
endmodule : tb
